// ---- hdl/cvlt_map.vh ----
// What this block does
// - an exposure sync pulse starts integration and, once it ends, the frame is read out.
// - the exposure sync comes from an internal generator or from the external pin, as chosen by the sync source input.
// - in pulse-width exposure mode the device integrates for as long as the exposure sync stays high.
// - line valid is high while a valid line's pixels are sent, frame valid high while a valid frame is sent.
// - data valid is high for valid pixel words, which the receiver captures on the rising strobe edge.
// - pixels are 10 bits and either the top 8 bits or all 10 bits go out, by link mode.
// - after reset the device runs internal sync, programmed exposure mode 2 and link mode 2.
// - link mode 2 is two taps of 8 bits, link mode 3 is two taps of 10 bits.
`ifndef CVLT_MAP_VH
`define CVLT_MAP_VH
`define CVLT_LINK_MODE_8 2'h2
`define CVLT_LINK_MODE_10 2'h3
`define CVLT_EXP_MODE_PROG 4'h2
`define CVLT_EXP_MODE_PW 4'h4
`define CVLT_SYNC_INTERNAL 1'h0
`define CVLT_SYNC_EXTERNAL 1'h1
`define CVLT_RST_LINK_MODE 2'h2
`define CVLT_RST_EXP_MODE 4'h2
`define CVLT_RST_SYNC_SRC 1'h0
`define CVLT_PIX_W 10
`define CVLT_OUT_W 8
`endif

// ---- hdl/cvlt_sync2.v ----
`timescale 1ns/1ns
module cvlt_sync2 (
  clk_sys,
  rst_b,
  d_in,
  q_out
);
  input clk_sys;
  input rst_b;
  input d_in;
  output q_out;
  reg meta_r;
  reg q_r;
  assign q_out = q_r;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
endmodule // cvlt_sync2

// ---- hdl/cvlt_link.v ----
`timescale 1ns/1ns
`include "cvlt_map.vh"
module cvlt_link #(
  parameter LINE_PIX = 16,
  parameter FRAME_LINES = 8,
  parameter LINE_GAP = 4,
  parameter EXP_CYC = 64,
  parameter PERIOD_CYC = 1024
) (
  input clk_sys,
  input rst_b,
  input exposure_sync_trigger,
  input sync_src,
  input [3:0] exp_mode,
  input [1:0] link_mode,
  input cfg_load,
  input [9:0] pix_in,
  output pix_req,
  output integrating,
  output reg lval_r,
  output reg fval_r,
  output reg dval_r,
  output strobe,
  output reg [7:0] port_a_r,
  output reg [7:0] port_b_r,
  output reg [7:0] port_c_r
);
  localparam S_IDLE = 4'b0001;
  localparam S_EXP = 4'b0010;
  localparam S_LINE = 4'b0100;
  localparam S_GAP = 4'b1000;

  function [7:0] top8;
    input [9:0] p;
    top8 = p[9:2];
  endfunction

  // 8-bit mode keeps only the top bits; 10-bit mode spreads each pixel over two ports
  function [7:0] word_a;
    input [1:0] mode;
    input [9:0] t1;
    begin
      if (mode == `CVLT_LINK_MODE_10) begin
        word_a = t1[7:0];
      end else begin
        word_a = top8(t1);
      end
    end
  endfunction

  function [7:0] word_b;
    input [1:0] mode;
    input [9:0] t1;
    input [9:0] t2;
    begin
      if (mode == `CVLT_LINK_MODE_10) begin
        word_b = {2'h0, t2[9:8], 2'h0, t1[9:8]};
      end else begin
        word_b = top8(t2);
      end
    end
  endfunction

  function [7:0] word_c;
    input [1:0] mode;
    input [9:0] t2;
    begin
      if (mode == `CVLT_LINK_MODE_10) begin
        word_c = t2[7:0];
      end else begin
        word_c = 8'h00;
      end
    end
  endfunction

  wire ext_sync;
  reg sync_src_r;
  reg [3:0] exp_mode_r;
  reg [1:0] link_mode_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [31:0] per_cnt_r;
  reg [31:0] exp_cnt_r;
  reg [15:0] pix_cnt_r;
  reg [15:0] line_cnt_r;
  reg int_sync_r;
  reg tap_r;
  reg [9:0] tap1_r;
  reg strobe_r;
  wire sync_lvl;
  wire sync_rise;
  wire sync_fall;
  reg sync_d_r;

  cvlt_sync2 u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d_in(exposure_sync_trigger),
    .q_out(ext_sync)
  );

  // internal generator: high for EXP_CYC each PERIOD_CYC
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_r <= 32'h00000000;
      int_sync_r <= 1'b0;
    end else begin
      per_cnt_r <= (per_cnt_r >= PERIOD_CYC - 1) ? 32'h00000000 : per_cnt_r + 32'h00000001;
      int_sync_r <= (per_cnt_r < EXP_CYC);
    end
  end

  assign sync_lvl = (sync_src_r == `CVLT_SYNC_EXTERNAL) ? ext_sync : int_sync_r;
  assign sync_rise = sync_lvl & ~sync_d_r;
  assign sync_fall = ~sync_lvl & sync_d_r;
  assign integrating = (state_r == S_EXP);
  assign pix_req = (state_r == S_LINE) & tap_r;
  assign strobe = strobe_r;

  // configuration taken only between frames so a frame never changes format midway
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_src_r <= `CVLT_RST_SYNC_SRC;
      exp_mode_r <= `CVLT_RST_EXP_MODE;
      link_mode_r <= `CVLT_RST_LINK_MODE;
    end else if (cfg_load && state_r == S_IDLE) begin
      sync_src_r <= sync_src;
      exp_mode_r <= exp_mode;
      link_mode_r <= (link_mode == `CVLT_LINK_MODE_10) ? `CVLT_LINK_MODE_10 : `CVLT_LINK_MODE_8;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (sync_rise) state_nxt = S_EXP;
      end
      S_EXP: begin
        if (exp_mode_r == `CVLT_EXP_MODE_PW) begin
          if (sync_fall) state_nxt = S_LINE;
        end else if (exp_cnt_r >= EXP_CYC - 1) begin
          state_nxt = S_LINE;
        end
      end
      S_LINE: begin
        if (tap_r && pix_cnt_r >= LINE_PIX - 2) state_nxt = S_GAP;
      end
      S_GAP: begin
        if (pix_cnt_r >= LINE_GAP - 1) begin
          state_nxt = (line_cnt_r >= FRAME_LINES - 1) ? S_IDLE : S_LINE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // state and counters
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      sync_d_r <= 1'b0;
      exp_cnt_r <= 32'h00000000;
      pix_cnt_r <= 16'h0000;
      line_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      sync_d_r <= sync_lvl;
      exp_cnt_r <= (state_r == S_EXP) ? exp_cnt_r + 32'h00000001 : 32'h00000000;
      if (state_r != state_nxt) begin
        pix_cnt_r <= 16'h0000;
      end else begin
        pix_cnt_r <= pix_cnt_r + 16'h0001;
      end
      if (state_r == S_EXP) begin
        line_cnt_r <= 16'h0000;
      end else if (state_r == S_GAP && state_nxt == S_LINE) begin
        line_cnt_r <= line_cnt_r + 16'h0001;
      end
    end
  end

  // strobe free-runs so the receiver's clock never stalls between lines
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tap_r <= 1'b0;
      tap1_r <= 10'h000;
      strobe_r <= 1'b0;
    end else begin
      // two pixels per word: first sample held, second completes the tap pair
      tap_r <= (state_r == S_LINE) ? ~tap_r : 1'b0;
      strobe_r <= ~strobe_r;
      if (state_r == S_LINE && !tap_r) begin
        tap1_r <= pix_in;
      end
    end
  end

  // ports hold the last word between data valid pulses
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_a_r <= 8'h00;
      port_b_r <= 8'h00;
      port_c_r <= 8'h00;
    end else if (state_r == S_LINE && tap_r) begin
      port_a_r <= word_a(link_mode_r, tap1_r);
      port_b_r <= word_b(link_mode_r, tap1_r, pix_in);
      port_c_r <= word_c(link_mode_r, pix_in);
    end
  end

  // qualifiers registered with the data so they arrive in the same cycle
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lval_r <= 1'b0;
      fval_r <= 1'b0;
      dval_r <= 1'b0;
    end else begin
      dval_r <= (state_r == S_LINE) && tap_r;
      lval_r <= (state_r == S_LINE);
      fval_r <= (state_r == S_LINE) || (state_r == S_GAP);
    end
  end
endmodule // cvlt_link

// ---- test/cvlt_grab.sv ----
`timescale 1ns/1ns
module cvlt_grab (
  input wire clk_sys,
  input wire dval_r,
  input wire [23:0] word,
  output int n_word,
  output logic [23:0] last_w
);
  initial n_word = 0;
  always @(posedge clk_sys) if (dval_r) begin
    n_word <= n_word + 1;
    last_w <= word;
  end
endmodule // cvlt_grab

// ---- test/cvlt_link_properties.sv ----
`timescale 1ns/1ns
module cvlt_link_properties #(parameter LINE_PIX = 16) (
  input logic clk_sys,
  input logic rst_b,
  input logic integrating,
  input logic lval_r,
  input logic fval_r,
  input logic dval_r,
  input logic strobe
);
  int n_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always @(posedge clk_sys or negedge rst_b)
    if (!rst_b) n_r <= 0;
    else n_r <= lval_r ? n_r + 1 : 0;
  sequence s_word; ##1 dval_r; endsequence
  property p_lv_fv; lval_r |-> fval_r; endproperty
  property p_dv_lv; dval_r |-> lval_r; endproperty
  property p_stb; strobe |=> !strobe; endproperty
  property p_dv_alt; dval_r |=> !dval_r; endproperty
  property p_len; $fell(lval_r) |-> n_r == LINE_PIX; endproperty
  property p_int; integrating |-> !fval_r; endproperty
  property p_first; $rose(lval_r) |-> s_word; endproperty
  property p_fv_up; $rose(fval_r) |-> lval_r; endproperty
  a_lv_fv: assert property (p_lv_fv) else $error("line outside frame");
  a_dv_lv: assert property (p_dv_lv) else $error("data outside line");
  a_stb: assert property (p_stb) else $error("strobe stuck");
  a_dv_alt: assert property (p_dv_alt) else $error("data valid too long");
  a_len: assert property (p_len) else $error("line length");
  a_int: assert property (p_int) else $error("readout during exposure");
  a_first: assert property (p_first) else $error("first word late");
  a_fv_up: assert property (p_fv_up) else $error("frame without line");
endmodule // cvlt_link_properties
bind cvlt_link cvlt_link_properties #(.LINE_PIX(LINE_PIX)) u_chk (.clk_sys, .rst_b,
  .integrating, .lval_r, .fval_r, .dval_r, .strobe);

// ---- test/cvlt_link_tb.sv ----
`timescale 1ns/1ns
module cvlt_link_tb;
  logic clk_sys = 0, rst_b = 0, ext = 0, src = 0, cfg = 0;
  logic [3:0] em = 4'h2;
  logic [1:0] lm = 2'h2;
  wire integ, lv, fv, dv, preq;
  logic [9:0] pix = 10'h2D5;
  wire [7:0] pa, pb, pc;
  wire [23:0] last_w;
  int n_word, n0, n_mismatch = 0, comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  // distinct first and second pixel so tap order is visible
  always @(negedge clk_sys) pix <= preq ? 10'h1C3 : 10'h2D5;
  cvlt_link #(.LINE_PIX(4), .FRAME_LINES(2), .LINE_GAP(2), .EXP_CYC(8), .PERIOD_CYC(200))
  i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .exposure_sync_trigger(ext), .sync_src(src),
    .exp_mode(em), .link_mode(lm), .cfg_load(cfg), .pix_in(pix), .pix_req(preq),
    .integrating(integ), .lval_r(lv), .fval_r(fv), .dval_r(dv), .strobe(),
    .port_a_r(pa), .port_b_r(pb), .port_c_r(pc));
  cvlt_grab i_grab (.clk_sys(clk_sys), .dval_r(dv), .word({pa, pb, pc}),
    .n_word(n_word), .last_w(last_w));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wt(input int k, input logic v);
    int i;
    for (i = 0; i < 3000 && (k ? integ : fv) !== v; i++) @(negedge clk_sys);
    if (i == 3000) begin
      n_mismatch++;
      results;
    end
  endtask
  task frame(input logic [23:0] exp);
    wt(0, 1);
    wt(0, 0);
    chk(24'(n_word - n0), 24'h4);
    chk(last_w, exp);
  endtask
  task setup(input logic s, input logic [3:0] e, input logic [1:0] l);
    wt(1, 0);
    src = s;
    em = e;
    lm = l;
    cfg = 1;
    @(negedge clk_sys);
    cfg = 0;
  endtask
  task t_default;
    chk({pa, pb, pc, fv, lv, dv}, 0);
    n0 = n_word;
    frame(24'hB57000);
  endtask
  task t_ext10;
    setup(1'h1, 4'h2, 2'h3);
    n0 = n_word;
    repeat (300) @(negedge clk_sys);
    chk(24'(n_word - n0), 0);
    ext = 1;
    repeat (8) @(negedge clk_sys);
    ext = 0;
    frame(24'hD512C3);
  endtask
  task t_pw;
    setup(1'h1, 4'h4, 2'h2);
    ext = 1;
    repeat (40) @(negedge clk_sys);
    chk(integ, 1);
    n0 = n_word;
    ext = 0;
    wt(1, 0);
    frame(24'hB57000);
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_b = 1;
    t_default;
    t_ext10;
    t_pw;
    results;
  end
endmodule // cvlt_link_tb
